// ### dv/iec_bus_peer.sv
// bus-side peer model: ends transfers lat+2 cycles after xfer_start and STOPs lat+1 cycles after stop_issue rises
// assumes start and stop requests of iec_ctrl on core_clk
`timescale 1ns/100ps
module iec_bus_peer
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       xfer_start,
	input  wire logic       stop_issue,
	input  wire logic [3:0] lat,
	output logic            xfer_done,
	output logic            stop_done
);
	logic [3:0] xfer_cnt;
	logic [3:0] stop_cnt;
	logic       busy;
	// ==========
	// wire timing
	always_ff @(posedge core_clk)
	begin
		busy      <= nrst && (busy && xfer_cnt != 4'h0 || xfer_start);
		xfer_cnt  <= xfer_start ? lat : xfer_cnt - 4'h1;
		xfer_done <= busy && xfer_cnt == 4'h0;
		stop_cnt  <= stop_issue && !stop_done ? stop_cnt + 4'h1 : 4'h0;
		stop_done <= stop_issue && !stop_done && stop_cnt == lat;
	end
endmodule : iec_bus_peer

// ### dv/iec_ctrl_asserts.sv
// concurrent checks on the ports of iec_ctrl
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module iec_ctrl_asserts
(
	input wire logic                 core_clk,
	input wire logic                 nrst,
	input wire iec_pkg::iec_bus_req_s bus_req,
	input wire logic [31:0]          rdata,
	input wire logic                 tx_fifo_empty,
	input wire logic                 general_call_irq_evt,
	input wire logic                 xfer_done,
	input wire logic                 stop_done,
	input wire logic                 xfer_start,
	input wire logic                 stop_issue,
	input wire logic                 tx_flush,
	input wire logic                 rx_flush,
	input wire logic                 irq
);
	import iec_pkg::*;
	logic en_q;
	logic blk_q;
	// ==========
	// shadow of software control bits
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			{blk_q, en_q} <= 2'h0;
		else if (bus_req.wr && bus_req.addr == IEC_ENABLE_CTRL_OFS)
			{blk_q, en_q} <= {bus_req.wdata[2], bus_req.wdata[0]};
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	chk_block_start: assert property (blk_q |-> !xfer_start) else $error("start while blocked");
	chk_start_data: assert property (xfer_start |-> !tx_fifo_empty && en_q) else $error("bad start");
	chk_stop_hold: assert property (stop_issue && !stop_done |=> stop_issue) else $error("stop dropped");
	chk_stop_flush: assert property (stop_issue && stop_done |=> tx_flush && !stop_issue) else $error("no flush");
	chk_flush_cause: assert property ($rose(tx_flush) && en_q |-> $past(stop_done)) else $error("flush early");
	chk_rx_flush: assert property (rx_flush == !en_q) else $error("rx flush wrong");
	chk_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 32'h0) else $error("rdata not zero");
	chk_ctrl_rsvd: assert property (bus_req.rd && bus_req.addr == IEC_ENABLE_CTRL_OFS
		|=> rdata[31:3] == 29'h0) else $error("reserved set");
	chk_clr_rsvd: assert property (bus_req.rd && bus_req.addr == IEC_GENERAL_CALL_IRQ_CLR_OFS
		|=> rdata[31:1] == 31'h0) else $error("reserved set");
	cover property (xfer_start);
	cover property (stop_done ##1 tx_flush);
	cover property (irq);
endmodule : iec_ctrl_asserts
bind iec_ctrl iec_ctrl_asserts u_chk (.core_clk, .nrst, .bus_req, .rdata, .tx_fifo_empty, .general_call_irq_evt,
	.xfer_done, .stop_done, .xfer_start, .stop_issue, .tx_flush, .rx_flush, .irq);

// ### dv/test_i2c_enable_abort_control.sv
// self-checking bench for iec_ctrl with a bus-side peer
// assumes the checker is bound from its own file
`timescale 1ns/100ps
module test_i2c_enable_abort_control;
	import iec_pkg::*;
	localparam logic [7:0] CTL = IEC_ENABLE_CTRL_OFS;
	localparam logic [7:0] STA = IEC_IRQ_STAT_OFS;
	localparam logic [7:0] RAW = IEC_RAW_INTR_OFS;
	logic core_clk = 1'b0, nrst = 1'b0, tx_fifo_empty = 1'b1, general_call_irq_evt = 1'b0, rd_pend = 1'b0;
	logic xfer_done, stop_done, xfer_start, stop_issue, tx_flush, rx_flush, irq;
	logic fill = 1'b0;
	logic [3:0] lat = 4'h2;
	logic [31:0] rdata;
	logic [31:0] exp_q[$];
	iec_bus_req_s bus_req = '0;
	int bad_count = 0, num_checks = 0, starts = 0;
	always #25 core_clk = ~core_clk;
	iec_ctrl DUT (.core_clk, .nrst, .bus_req, .rdata, .tx_fifo_empty, .general_call_irq_evt, .xfer_done,
		.stop_done, .xfer_start, .stop_issue, .tx_flush, .rx_flush, .irq);
	iec_bus_peer u_peer (.core_clk, .nrst, .xfer_start, .stop_issue, .lat, .xfer_done, .stop_done);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic give_verdict;
		if (bad_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		bus_req <= '{a, d, w, r};
		@(posedge core_clk);
	endtask : op
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		op(1'b0, 1'b1, a, 32'h0);
	endtask : rd
	// ==========
	// read results and peer-side fifo
	always @(posedge core_clk)
	begin
		if (rd_pend)
			chk(rdata, exp_q.pop_front());
		rd_pend <= bus_req.rd;
		starts += xfer_start;
		if (tx_flush)
			tx_fifo_empty <= 1'b1;
		else if (fill)
			tx_fifo_empty <= 1'b0;
	end
	initial
	begin
		void'($urandom(32'h5E014FCB));
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		rd(CTL, 32'h0);
		op(1'b1, 1'b0, CTL, 32'h2);
		rd(CTL, 32'h0);
		rd(IEC_STATUS_OFS, 32'h4);
		op(1'b1, 1'b0, CTL, $urandom & 32'hFFFFFFF8 | 32'h5);
		rd(CTL, 32'h5);
		fill <= 1'b1;
		repeat (4) op(1'b0, 1'b0, 8'h00, 32'h0);
		chk(starts, 0);
		lat <= 4'($urandom_range(4, 9));
		op(1'b1, 1'b0, CTL, 32'h1);
		repeat (2) op(1'b0, 1'b0, 8'h00, 32'h0);
		chk(starts, 1);
		fill <= 1'b0;
		op(1'b1, 1'b0, CTL, 32'h3);
		op(1'b1, 1'b0, CTL, 32'h1);
		rd(CTL, 32'h3);
		rd(IEC_STATUS_OFS, 32'h20);
		for (int i = 0; tx_flush !== 1'b1; i++)
		begin
			if (i == 80)
			begin
				bad_count++;
				break;
			end
			op(1'b0, 1'b0, 8'h00, 32'h0);
		end
		repeat (2) op(1'b0, 1'b0, 8'h00, 32'h0);
		rd(CTL, 32'h1);
		rd(STA, 32'h6);
		chk(irq, 0);
		op(1'b1, 1'b0, IEC_IRQ_MASK_OFS, 32'h2);
		rd(IEC_IRQ_MASK_OFS, 32'h2);
		chk(irq, 1);
		op(1'b1, 1'b0, STA, 32'h2);
		op(1'b0, 1'b0, 8'h00, 32'h0);
		chk(irq, 0);
		rd(STA, 32'h4);
		general_call_irq_evt <= 1'b1;
		op(1'b0, 1'b0, 8'h00, 32'h0);
		general_call_irq_evt <= 1'b0;
		rd(RAW, 32'h800);
		rd(IEC_GENERAL_CALL_IRQ_CLR_OFS, 32'h1);
		rd(RAW, 32'h0);
		op(1'b1, 1'b0, 8'hFC, 32'hFFFFFFFF);
		rd(8'hFC, 32'h0);
		op(1'b1, 1'b0, CTL, 32'h0);
		repeat (3) op(1'b0, 1'b0, 8'h00, 32'h0);
		give_verdict();
	end
endmodule : test_i2c_enable_abort_control

// ### rtl/iec_ctrl.sv
// enable/abort/command-block control with general-call clear and interrupts
// assumes a single-cycle register port and an external protocol engine
//
// Summary of operation
// [R1] reading clear register drops general-call flag
// [R2] command block set: no bus transmission starts
// [R3] block clear: transmit starts on first entry
// [R4] software blocks only when fifo empty, idle
// [R5] queued commands held until block cleared
// [R6] abort write accepted only while enabled
// [R7] writing zero cannot clear set abort
// [R8] abort: finish transfer, stop, flush, interrupt
// [R9] hardware clears abort when finished
// [R10] abort bit one while abort in progress
// [R11] block field bit two, reserved above
// [R12] disabled: fifos flushed, transfer wound down
// [R13] reserved bits read zero, writes ignored
`timescale 1ns/100ps
module iec_ctrl
(
	input  wire logic                  core_clk,
	input  wire logic                  nrst,
	input  wire iec_pkg::iec_bus_req_s bus_req,
	output logic [31:0]       rdata,
	input  wire logic         tx_fifo_empty,
	input  wire logic         general_call_irq_evt,
	input  wire logic         xfer_done,
	input  wire logic         stop_done,
	output logic              xfer_start,
	output logic              stop_issue,
	output logic              tx_flush,
	output logic              rx_flush,
	output logic              irq
);
	import iec_pkg::*;

	logic                 enable_reg;
	logic                 abort_reg;
	logic                 cmd_block_reg;
	logic [IEC_IRQ_W-1:0] mask_reg;
	logic [IEC_IRQ_W-1:0] flags;
	logic [IEC_IRQ_W-1:0] set_pulse;
	logic [IEC_IRQ_W-1:0] clr_bits;
	logic                 seq_flush;
	logic                 abort_done;
	logic                 master_active;
	logic                 wr_en;
	logic                 wr_mask;
	logic                 wr_stat;
	logic                 rd_gc;
	logic [31:0]          rdata_next;

	// ==========================================================
	// decode
	always_comb
	begin
		wr_en   = 1'b0;
		wr_mask = 1'b0;
		wr_stat = 1'b0;
		rd_gc   = 1'b0;
		if (bus_req.wr && iec_hit(bus_req.addr, IEC_ENABLE_CTRL_OFS))
			wr_en = 1'b1;
		else if (bus_req.wr && iec_hit(bus_req.addr, IEC_IRQ_MASK_OFS))
			wr_mask = 1'b1;
		else if (bus_req.wr && iec_hit(bus_req.addr, IEC_IRQ_STAT_OFS))
			wr_stat = 1'b1;
		else if (bus_req.rd && iec_hit(bus_req.addr, IEC_GENERAL_CALL_IRQ_CLR_OFS))
			rd_gc = 1'b1;
	end

	// ==========================================================
	// enable and command block
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			enable_reg    <= IEC_ENABLE_RST;
			cmd_block_reg <= IEC_CMD_BLOCK_RST;
		end
		else if (wr_en)
		begin
			enable_reg    <= bus_req.wdata[IEC_ENABLE_BIT];
			cmd_block_reg <= bus_req.wdata[IEC_CMD_BLOCK_BIT]; // R11 R13
		end
	end

	// ==========================================================
	// abort bit: set only when enabled, cleared by hardware
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			abort_reg <= IEC_ABORT_RST;
		else if (abort_done)
			abort_reg <= 1'b0; // R9
		else if (wr_en && enable_reg && bus_req.wdata[IEC_ABORT_BIT])
			abort_reg <= 1'b1; // R6 R7
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			mask_reg <= IEC_IRQ_RST;
		else if (wr_mask)
			mask_reg <= bus_req.wdata[IEC_IRQ_W-1:0];
	end

	// ==========================================================
	// master sequencing
	iec_master_seq u_seq (
		.core_clk      (core_clk),
		.nrst          (nrst),
		.enable        (enable_reg),
		.cmd_block     (cmd_block_reg), // R2 R3 R5
		.abort_req     (abort_reg),     // R8
		.tx_fifo_empty (tx_fifo_empty),
		.xfer_done     (xfer_done),
		.stop_done     (stop_done),
		.xfer_start    (xfer_start),
		.stop_issue    (stop_issue),
		.tx_flush      (seq_flush),
		.abort_done    (abort_done),
		.master_active (master_active)
	);

	assign tx_flush = seq_flush || (!enable_reg && !master_active); // R12
	assign rx_flush = !enable_reg; // R12

	// ==========================================================
	// interrupts
	assign set_pulse = {abort_done, abort_done, general_call_irq_evt}; // R8
	assign clr_bits  = (wr_stat ? bus_req.wdata[IEC_IRQ_W-1:0] : IEC_IRQ_RST)
		| {2'b00, rd_gc}; // R1

	iec_sticky u_sticky (
		.core_clk  (core_clk),
		.nrst      (nrst),
		.set_pulse (set_pulse),
		.clr_bits  (clr_bits),
		.flags     (flags)
	);

	assign irq = |(flags & mask_reg);

	// ==========================================================
	// read mux
	always_comb
	begin
		rdata_next = 32'h0; // R13
		if (iec_hit(bus_req.addr, IEC_ENABLE_CTRL_OFS))
		begin
			rdata_next[IEC_ENABLE_BIT]    = enable_reg;
			rdata_next[IEC_ABORT_BIT]     = abort_reg; // R10
			rdata_next[IEC_CMD_BLOCK_BIT] = cmd_block_reg;
		end
		else if (iec_hit(bus_req.addr, IEC_GENERAL_CALL_IRQ_CLR_OFS))
			rdata_next[0] = flags[0];
		else if (iec_hit(bus_req.addr, IEC_RAW_INTR_OFS))
			rdata_next[IEC_GENERAL_CALL_IRQ_BIT] = flags[0];
		else if (iec_hit(bus_req.addr, IEC_STATUS_OFS))
		begin
			rdata_next[IEC_TFE_BIT]     = tx_fifo_empty; // R4
			rdata_next[IEC_MST_ACT_BIT] = master_active;
		end
		else if (iec_hit(bus_req.addr, IEC_IRQ_STAT_OFS))
			rdata_next[IEC_IRQ_W-1:0] = flags;
		else if (iec_hit(bus_req.addr, IEC_IRQ_MASK_OFS))
			rdata_next[IEC_IRQ_W-1:0] = mask_reg;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			rdata <= 32'h0;
		else if (bus_req.rd)
			rdata <= rdata_next;
		else
			rdata <= 32'h0;
	end
endmodule : iec_ctrl

// ### rtl/iec_master_seq.sv
// master sequencer: starts transfers, runs abort as transfer end, stop, flush
// assumes the protocol engine reports transfer done and stop done pulses
`timescale 1ns/100ps
module iec_master_seq
(
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic enable,
	input  wire logic cmd_block,
	input  wire logic abort_req,
	input  wire logic tx_fifo_empty,
	input  wire logic xfer_done,
	input  wire logic stop_done,
	output logic      xfer_start,
	output logic      stop_issue,
	output logic      tx_flush,
	output logic      abort_done,
	output logic      master_active
);
	import iec_pkg::*;

	iec_mst_state_e state_reg;
	iec_mst_state_e state_next;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			IEC_IDLE:
				if (abort_req)
					state_next = IEC_STOP;
				else if (enable && !cmd_block && !tx_fifo_empty)
					state_next = IEC_XFER;
			IEC_XFER:
				if (xfer_done)
					state_next = (abort_req || !enable) ? IEC_STOP : IEC_IDLE;
			IEC_STOP:
				if (stop_done)
					state_next = IEC_FLUSH;
			IEC_FLUSH:
				state_next = IEC_IDLE;
			default:
				state_next = IEC_IDLE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			state_reg <= IEC_IDLE;
		else
			state_reg <= state_next;
	end

	assign xfer_start    = (state_reg == IEC_IDLE) && (state_next == IEC_XFER);
	assign stop_issue    = (state_reg == IEC_STOP);
	assign tx_flush      = (state_reg == IEC_FLUSH);
	assign abort_done    = (state_reg == IEC_FLUSH) && abort_req;
	assign master_active = (state_reg != IEC_IDLE);
endmodule : iec_master_seq

// ### rtl/iec_pkg.sv
// package for the enable/abort/general-call control block
// assumes one clock domain and a plain register port
package iec_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] IEC_GENERAL_CALL_IRQ_CLR_OFS = 8'h68;
	localparam logic [7:0] IEC_ENABLE_CTRL_OFS  = 8'h6C;
	localparam logic [7:0] IEC_RAW_INTR_OFS     = 8'h34;
	localparam logic [7:0] IEC_STATUS_OFS       = 8'h70;
	localparam logic [7:0] IEC_IRQ_STAT_OFS     = 8'h80;
	localparam logic [7:0] IEC_IRQ_MASK_OFS     = 8'h84;
	// ==========================================================
	// field positions
	localparam int IEC_ENABLE_BIT    = 0;
	localparam int IEC_ABORT_BIT     = 1;
	localparam int IEC_CMD_BLOCK_BIT = 2;
	localparam int IEC_GENERAL_CALL_IRQ_BIT  = 11;
	localparam int IEC_TFE_BIT       = 2;
	localparam int IEC_MST_ACT_BIT   = 5;
	// ==========================================================
	// reset values
	localparam logic       IEC_ENABLE_RST    = 1'b0;
	localparam logic       IEC_ABORT_RST     = 1'b0;
	localparam logic       IEC_CMD_BLOCK_RST = 1'b0;
	localparam logic [2:0] IEC_IRQ_RST       = 3'h0;
	// interrupt status layout: bit0 general call, bit1 tx abort, bit2 abort done
	localparam int IEC_IRQ_W = 3;
	// ==========================================================
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} iec_bus_req_s;

	typedef enum logic [1:0] {
		IEC_IDLE    = 2'b00,
		IEC_XFER    = 2'b01,
		IEC_STOP    = 2'b10,
		IEC_FLUSH   = 2'b11
	} iec_mst_state_e;

	function automatic logic iec_hit(input logic [7:0] a, input logic [7:0] ofs);
		iec_hit = (a == ofs);
	endfunction : iec_hit
endpackage : iec_pkg

// ### rtl/iec_sticky.sv
// sticky event bits with write-one-to-clear; set wins over clear
// assumes events are one-cycle pulses on core_clk
`timescale 1ns/100ps
module iec_sticky
(
	input  wire logic                          core_clk,
	input  wire logic                          nrst,
	input  wire logic [iec_pkg::IEC_IRQ_W-1:0] set_pulse,
	input  wire logic [iec_pkg::IEC_IRQ_W-1:0] clr_bits,
	output logic      [iec_pkg::IEC_IRQ_W-1:0] flags
);
	import iec_pkg::*;

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			flags <= IEC_IRQ_RST;
		else
			flags <= (flags & ~clr_bits) | set_pulse;
	end
endmodule : iec_sticky
